//--- include/jtp_pkg.sv
// Package: constants and types of the four-wire test access port
package jtp_pkg;

  // ==========================================================
  // Sizes
  localparam int IR_W   = 10;
  localparam int DR_W   = 32;
  localparam int IO_W   = 8;
  localparam int BSR_W  = 3 * IO_W;
  localparam int CFG_W  = 8;
  localparam int ANA_W  = 16;
  localparam int ANA_CW = 3;

  // ==========================================================
  // Opcodes, values arbitrary
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_W-1:0] OP_CFG    = 10'h002;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] OP_USER   = 10'h007;
  localparam logic [IR_W-1:0] OP_ANA    = 10'h00e;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
  localparam logic [IR_W-1:0] IR_CAPT   = 10'h001;

  // ==========================================================
  // Identification fields, values arbitrary
  localparam logic [3:0]  ID_VER  = 4'h0;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MFR  = 11'h2a5;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } jtp_tap_t;

  typedef enum logic [2:0] {
    SEL_BYP, SEL_IDC, SEL_USR, SEL_SMP, SEL_EXT, SEL_CFG, SEL_ANA
  } jtp_sel_t;

  typedef struct packed {
    logic [IO_W-1:0] out;
    logic [IO_W-1:0] oe;
  } jtp_pins_t;

  typedef struct packed {
    jtp_tap_t         state;
    logic [IR_W-1:0]  ir_sh;
    logic [IR_W-1:0]  ir;
    jtp_sel_t         sel;
    logic             ext;
    logic [DR_W-1:0]  dr;
    logic [BSR_W-1:0] upd;
  } jtp_tck_st_t;

  typedef struct packed {
    jtp_pins_t         pins;
    logic [ANA_CW-1:0] ana_cnt;
  } jtp_sys_st_t;

endpackage

//--- rtl/jtp_sync.sv
// Two-stage synchroniser for levels
`timescale 1ns/10ps
module jtp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jtp_sync_st_t;

  jtp_sync_st_t st_q, st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.s2;
endmodule

//--- rtl/jtp_xfer.sv
// Toggle handshake that moves a held word between clock domains
`timescale 1ns/10ps
module jtp_xfer #(
  parameter int W = 8
) (
  // Clocks and reset
  input  wire logic         src_clk_i,
  input  wire logic         dst_clk_i,
  input  wire logic         rst_n_i,
  // Source side
  input  wire logic         send_i,
  input  wire logic [W-1:0] data_i,
  // Destination side
  output logic      [W-1:0] data_o,
  output logic              stb_o
);
  typedef struct packed {
    logic         tg;
    logic [W-1:0] data;
  } jtp_xsrc_st_t;

  typedef struct packed {
    logic         last;
    logic         stb;
    logic [W-1:0] data;
  } jtp_xdst_st_t;

  jtp_xsrc_st_t src_q, src_d;
  jtp_xdst_st_t dst_q, dst_d;
  logic         tg_s;

  // ==========================================================
  // Source: word is held until the next send
  always_comb begin
    src_d = src_q;
    if (send_i) begin
      src_d.tg   = ~src_q.tg;
      src_d.data = data_i;
    end
  end

  always_ff @(posedge src_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q <= '0;
    end else begin
      src_q <= src_d;
    end
  end

  jtp_sync #(.W(1)) u_tg_sync (
    .clk_i   (dst_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (src_q.tg),
    .q_o     (tg_s)
  );

  // ==========================================================
  // Destination: sends closer than three destination clocks are lost
  always_comb begin
    dst_d      = dst_q;
    dst_d.last = tg_s;
    dst_d.stb  = tg_s ^ dst_q.last;
    if (tg_s ^ dst_q.last) begin
      dst_d.data = src_q.data;
    end
  end

  always_ff @(posedge dst_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dst_q <= '0;
    end else begin
      dst_q <= dst_d;
    end
  end

  assign data_o = dst_q.data;
  assign stb_o  = dst_q.stb;
endmodule

//--- rtl/jtp_tap_top.sv
// Test access port: controller, data registers, pin and configuration crossings
`timescale 1ns/10ps
module jtp_tap_top #(
  parameter logic        SCAN_EN   = 1'b1,
  parameter logic [31:0] USER_CODE = 32'h0000_0000
) (
  // System side
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  // Test link
  input  wire logic                       tck_i,
  input  wire logic                       tms_i,
  input  wire logic                       tdi_i,
  output logic                            tdo_o,
  output logic                            tdo_oe_o,
  // Pins and core
  input  wire logic [jtp_pkg::IO_W-1:0]   pin_i,
  input  wire jtp_pkg::jtp_pins_t         core_i,
  output jtp_pkg::jtp_pins_t              pin_o,
  // Configuration and analyzer
  input  wire logic                       cfg_busy_i,
  output logic      [jtp_pkg::CFG_W-1:0]  cfg_byte_o,
  output logic                            cfg_stb_o,
  input  wire logic [jtp_pkg::ANA_W-1:0]  probe_i
);
  import jtp_pkg::*;

  // ==========================================================
  // Functions
  function automatic jtp_tap_t tap_next(jtp_tap_t s, logic m);
    jtp_tap_t r;
    r = s;
    unique case (s)
      TAP_TLR:    r = m ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    r = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: r = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: r = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  r = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: r = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  r = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: r = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: r = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: r = m ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: r = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  r = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: r = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  r = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: r = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: r = m ? TAP_SEL_DR : TAP_RTI;
    endcase
    return r;
  endfunction

  function automatic logic is_op(logic [IR_W-1:0] ir);
    return ir inside {OP_EXTEST, OP_CFG, OP_SAMPLE, OP_IDCODE, OP_USER, OP_ANA, OP_BYPASS};
  endfunction

  // Scan refused while configuring; scan and port configuration refused on the largest member
  function automatic jtp_sel_t ir_decode(logic [IR_W-1:0] ir, logic busy);
    jtp_sel_t r;
    r = SEL_BYP;
    if (ir == OP_ANA) begin
      r = SEL_ANA;
    end else if (SCAN_EN) begin
      if (ir == OP_IDCODE) r = SEL_IDC;
      if (ir == OP_USER) r = SEL_USR;
      if (ir == OP_CFG) r = SEL_CFG;
      if (ir == OP_SAMPLE && !busy) r = SEL_SMP;
      if (ir == OP_EXTEST && !busy) r = SEL_EXT;
    end
    return r;
  endfunction

  function automatic int dr_len(jtp_sel_t s);
    int r;
    r = 1;
    unique case (s)
      SEL_IDC, SEL_USR: r = DR_W;
      SEL_SMP, SEL_EXT: r = BSR_W;
      SEL_CFG:          r = CFG_W;
      SEL_ANA:          r = ANA_W;
      SEL_BYP:          r = 1;
    endcase
    return r;
  endfunction

  // Shift enters at the selected register's top, leaves at bit 0
  function automatic logic [DR_W-1:0] shift_dr(logic [DR_W-1:0] d, jtp_sel_t s, logic b);
    logic [DR_W-1:0] r;
    r = d >> 1;
    r[dr_len(s)-1] = b;
    return r;
  endfunction

  function automatic logic [DR_W-1:0] dr_capture(jtp_sel_t s, logic [BSR_W-1:0] upd,
                                                  logic [IO_W-1:0] pins, logic [ANA_W-1:0] ana,
                                                  logic busy);
    logic [DR_W-1:0] r;
    r = '0;
    unique case (s)
      SEL_IDC:          r = {ID_VER, ID_PART, ID_MFR, 1'b1};
      SEL_USR:          r = USER_CODE;
      SEL_SMP, SEL_EXT: r = {{(DR_W - BSR_W){1'b0}}, upd[BSR_W-1:IO_W], pins};
      SEL_ANA:          r = {{(DR_W - ANA_W){1'b0}}, ana};
      SEL_CFG:          r = {{(DR_W - 1){1'b0}}, busy};
      SEL_BYP:          r = '0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Crossings
  jtp_tck_st_t      t_q, t_d;
  jtp_sys_st_t      s_q, s_d;
  logic             busy_s;
  logic             ext_s;
  logic [IO_W-1:0]  pin_s;
  logic [BSR_W-1:0] upd_sys;
  logic [ANA_W-1:0] ana_tck;
  logic             upd_send;
  logic             cfg_send;
  logic             tdo_q;
  logic             tdo_oe_q;

  jtp_sync #(.W(1)) u_busy_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_n_i),
    .d_i     (cfg_busy_i),
    .q_o     (busy_s)
  );

  jtp_sync #(.W(IO_W)) u_pin_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_n_i),
    .d_i     (pin_i),
    .q_o     (pin_s)
  );

  jtp_sync #(.W(1)) u_ext_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (t_q.ext),
    .q_o     (ext_s)
  );

  assign upd_send = (t_q.state == TAP_UPD_DR) && (t_q.sel inside {SEL_SMP, SEL_EXT});
  assign cfg_send = (t_q.state == TAP_UPD_DR) && (t_q.sel == SEL_CFG);

  // Update cells carried to the pin flops in the system domain
  jtp_xfer #(.W(BSR_W)) u_upd_xfer (
    .src_clk_i (tck_i),
    .dst_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .send_i    (upd_send),
    .data_i    (t_q.dr[BSR_W-1:0]),
    .data_o    (upd_sys),
    .stb_o     ()
  );

  // Configuration bytes, one per update
  jtp_xfer #(.W(CFG_W)) u_cfg_xfer (
    .src_clk_i (tck_i),
    .dst_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .send_i    (cfg_send),
    .data_i    (t_q.dr[CFG_W-1:0]),
    .data_o    (cfg_byte_o),
    .stb_o     (cfg_stb_o)
  );

  // Probe snapshots at system speed, one every eight system clocks
  jtp_xfer #(.W(ANA_W)) u_ana_xfer (
    .src_clk_i (sys_clk_i),
    .dst_clk_i (tck_i),
    .rst_n_i   (rst_n_i),
    .send_i    (s_q.ana_cnt == '0),
    .data_i    (probe_i),
    .data_o    (ana_tck),
    .stb_o     ()
  );

  // ==========================================================
  // Link domain
  always_comb begin
    t_d       = t_q;
    t_d.state = tap_next(t_q.state, tms_i);
    unique case (t_q.state)
      TAP_TLR: begin
        t_d.ir  = OP_IDCODE;
        t_d.sel = ir_decode(OP_IDCODE, busy_s);
        t_d.ext = 1'b0;
      end
      TAP_CAP_IR: t_d.ir_sh = IR_CAPT;
      TAP_SH_IR:  t_d.ir_sh = {tdi_i, t_q.ir_sh[IR_W-1:1]};
      TAP_UPD_IR: begin
        t_d.ir  = t_q.ir_sh;
        t_d.sel = ir_decode(t_q.ir_sh, busy_s);
        t_d.ext = (ir_decode(t_q.ir_sh, busy_s) == SEL_EXT);
      end
      TAP_CAP_DR: t_d.dr = dr_capture(t_q.sel, t_q.upd, pin_s, ana_tck, busy_s);
      TAP_SH_DR:  t_d.dr = shift_dr(t_q.dr, t_q.sel, tdi_i);
      TAP_UPD_DR: begin
        if (upd_send) t_d.upd = t_q.dr[BSR_W-1:0];
      end
      TAP_RTI, TAP_SEL_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
      TAP_SEL_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR: ;
    endcase
    // Configuration starting mid-test drops scan back to bypass
    if (busy_s && (t_d.sel inside {SEL_SMP, SEL_EXT})) begin
      t_d.sel = SEL_BYP;
      t_d.ext = 1'b0;
    end
  end

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_q.state <= TAP_TLR;
      t_q.ir_sh <= IR_CAPT;
      t_q.ir    <= OP_IDCODE;
      t_q.sel   <= SCAN_EN ? SEL_IDC : SEL_BYP;
      t_q.ext   <= 1'b0;
      t_q.dr    <= '0;
      t_q.upd   <= '0;
    end else begin
      t_q.state <= t_d.state;
      t_q.ir_sh <= t_d.ir_sh;
      t_q.ir    <= t_d.ir;
      t_q.sel   <= t_d.sel;
      t_q.ext   <= t_d.ext;
      t_q.dr    <= t_d.dr;
      t_q.upd   <= t_d.upd;
    end
  end

  // Output changes on the falling edge so the far end samples a settled bit
  always_ff @(negedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= (t_q.state == TAP_SH_IR) ? t_q.ir_sh[0] : t_q.dr[0];
      tdo_oe_q <= t_q.state inside {TAP_SH_IR, TAP_SH_DR};
    end
  end

  assign tdo_o    = tdo_q;
  assign tdo_oe_o = tdo_oe_q;

  // ==========================================================
  // System domain pins
  always_comb begin
    s_d         = s_q;
    s_d.ana_cnt = s_q.ana_cnt + 1'b1;
    if (ext_s) begin
      s_d.pins = {upd_sys[2*IO_W-1:IO_W], upd_sys[BSR_W-1:2*IO_W]};
    end else begin
      s_d.pins = core_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_o = s_q.pins;

  // ==========================================================
  // Checks
  sequence s_tms5;
    tms_i [*5];
  endsequence

  sequence s_cap(jtp_sel_t k);
    t_q.state == TAP_CAP_DR && t_q.sel == k;
  endsequence

  AST_TLR_FIVE: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    s_tms5 |=> t_q.state == TAP_TLR)
    else $error("Five high mode bits did not reach reset");

  AST_IR_CAPT: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    t_q.state == TAP_CAP_IR |=> t_q.ir_sh == IR_CAPT)
    else $error("Instruction capture value wrong");

  AST_BYP_CAPT: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    s_cap(SEL_BYP) |=> t_q.dr[0] == 1'b0)
    else $error("Bypass did not capture zero");

  AST_BYP_DELAY: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    t_q.state == TAP_SH_DR && t_q.sel == SEL_BYP |=> t_q.dr[0] == $past(tdi_i))
    else $error("Bypass delay not one clock");

  AST_ID_LSB: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    s_cap(SEL_IDC) |=> t_q.dr[0] && t_q.dr[11:1] == ID_MFR && t_q.dr[31:28] == ID_VER)
    else $error("Identification word malformed");

  AST_USR_LOAD: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    s_cap(SEL_USR) |=> t_q.dr == USER_CODE)
    else $error("User code not loaded");

  AST_UNASSIGNED: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    t_q.state == TAP_UPD_IR && !is_op(t_q.ir_sh) |=> t_q.sel == SEL_BYP)
    else $error("Unassigned opcode not bypass");

  AST_BUSY_BLOCK: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    busy_s |=> !(t_q.sel inside {SEL_SMP, SEL_EXT}) && !t_q.ext)
    else $error("Scan active during configuration");

  AST_LARGEST: assert property (@(posedge tck_i) disable iff (!rst_n_i)
    !SCAN_EN |-> t_q.sel inside {SEL_BYP, SEL_ANA})
    else $error("Unsupported instruction selected");

  AST_EXT_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ext_s |=> pin_o.out == $past(upd_sys[2*IO_W-1:IO_W]))
    else $error("Extest pins not from update cells");

  AST_SMP_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ext_s |=> pin_o == $past(core_i))
    else $error("Pins disturbed outside extest");
endmodule

//--- verif/jtp_ctrl_model.sv
// Test controller model: drives link clock, mode select and serial data
`timescale 1ns/10ps
module jtp_ctrl_model (
  // Link
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  import jtp_pkg::*;

  logic oe_bad;
  logic tdo_line;

  // Released line reads inverted, so a shift with the driver off shows up
  assign tdo_line = tdo_oe_i ? tdo_i : ~tdo_i;

  initial begin
    tck_o  = 1'b0;
    tms_o  = 1'b1;
    tdi_o  = 1'b0;
    oe_bad = 1'b0;
  end

  // ==========================================================
  // Clock pulses only inside tasks; stands still between frames
  task automatic tick(input logic m, input logic d, output logic s);
    tms_o = m;
    tdi_o = d;
    #7.5 tck_o = 1'b1;
    s = tdo_line;
    #7.5 tck_o = 1'b0;
  endtask

  // Data line unused here, so it toggles rather than holding a stale bit
  task automatic nav(input logic m);
    logic s;
    tick(m, ~tdi_o, s);
  endtask

  task automatic reset_tap();
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask

  // Run the link clock in idle so slow-side snapshots can arrive
  task automatic idle(input int n);
    repeat (n) nav(1'b0);
  endtask

  task automatic shift_ir(input logic [IR_W-1:0] op, output logic [IR_W-1:0] cap);
    logic s;
    nav(1'b1);
    nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < IR_W; i++) begin
      tick(i == IR_W - 1, op[i], s);
      cap[i] = s;
      if (tdo_oe_i !== 1'b1) oe_bad = 1'b1;
    end
    nav(1'b1);
    nav(1'b0);
  endtask

  task automatic shift_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
    logic s;
    dout = '0;
    nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], s);
      dout[i] = s;
      if (tdo_oe_i !== 1'b1) oe_bad = 1'b1;
    end
    nav(1'b1);
    nav(1'b0);
  endtask
endmodule

//--- verif/tb_jtag_test_access_port.sv
// Testbench of the test access port, full and largest-member builds
`timescale 1ns/10ps
module tb_jtag_test_access_port;
  import jtp_pkg::*;

  localparam logic [31:0] UCODE = 32'hc0de_5a17;

  logic             sys_clk_i, rst_n_i, cfg_busy_i, cfg_stb_o;
  logic             tck, tms, tdi, tdo, tdo_oe, tck2, tms2, tdi2, tdo2, tdo_oe2;
  logic [IO_W-1:0]  pin_i;
  jtp_pins_t        core_i, pin_o;
  logic [CFG_W-1:0] cfg_byte_o, stb_byte;
  logic [ANA_W-1:0] probe_i;
  logic [IR_W-1:0]  cap;
  logic [31:0]      d;
  int               err_count, checks, stb_cnt;

  jtp_tap_top #(.SCAN_EN(1'b1), .USER_CODE(UCODE)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_i(pin_i),
    .core_i(core_i), .pin_o(pin_o), .cfg_busy_i(cfg_busy_i), .cfg_byte_o(cfg_byte_o),
    .cfg_stb_o(cfg_stb_o), .probe_i(probe_i));
  jtp_tap_top #(.SCAN_EN(1'b0), .USER_CODE(UCODE)) dut2 (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .tck_i(tck2), .tms_i(tms2), .tdi_i(tdi2), .tdo_o(tdo2), .tdo_oe_o(tdo_oe2), .pin_i(pin_i),
    .core_i(core_i), .pin_o(), .cfg_busy_i(cfg_busy_i), .cfg_byte_o(), .cfg_stb_o(),
    .probe_i(probe_i));
  jtp_ctrl_model u_ctrl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  jtp_ctrl_model u_ctrl2 (.tck_o(tck2), .tms_o(tms2), .tdi_o(tdi2), .tdo_i(tdo2), .tdo_oe_i(tdo_oe2));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (cfg_stb_o === 1'b1) begin
      stb_cnt++;
      stb_byte = cfg_byte_o;
    end
  end

  // ==========================================================
  // Shared checks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pin path crosses domains, so allow a bounded settle
  task automatic wait_pin(input string what, input logic [15:0] exp);
    for (int i = 0; i < 20 && pin_o !== exp; i++) @(posedge sys_clk_i);
    check(what, {16'h0, exp}, {16'h0, pin_o});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_user();
    u_ctrl.shift_ir(OP_USER, cap);
    check("ir capture", {22'h0, IR_CAPT}, {22'h0, cap});
    u_ctrl.shift_dr(32'h0, 32, d);
    check("usercode", UCODE, d);
    $display("usercode test done");
  endtask

  task automatic t_idcode();
    u_ctrl.reset_tap();
    u_ctrl.shift_dr(32'h0, 32, d);
    check("idcode", {ID_VER, ID_PART, ID_MFR, 1'b1}, d);
    check("tdo enable", 32'h0, {31'h0, u_ctrl.oe_bad});
    $display("idcode test done");
  endtask

  task automatic t_bypass();
    logic [IR_W-1:0] ops [3];
    ops = '{OP_BYPASS, 10'h155, 10'h3fe};
    foreach (ops[i]) begin
      u_ctrl.shift_ir(ops[i], cap);
      u_ctrl.shift_dr(32'hc3, 8, d);
      check("bypass", 32'h86, d);
    end
    $display("bypass test done");
  endtask

  task automatic t_sample_extest();
    @(posedge sys_clk_i);
    core_i <= 16'h5a0f;
    pin_i  <= 8'h3c;
    u_ctrl.shift_ir(OP_SAMPLE, cap);
    u_ctrl.shift_dr({8'h0, 8'hff, 8'h81, 8'h00}, 24, d);
    check("sample pins", 32'h3c, {24'h0, d[7:0]});
    repeat (8) @(posedge sys_clk_i);
    check("pins during sample", 32'h5a0f, {16'h0, pin_o});
    u_ctrl.shift_ir(OP_EXTEST, cap);
    wait_pin("preloaded pins", 16'h81ff);
    u_ctrl.shift_dr({8'h0, 8'h33, 8'hc6, 8'h00}, 24, d);
    check("extest capture", 32'hff813c, d);
    wait_pin("extest pins", 16'hc633);
    u_ctrl.shift_ir(OP_BYPASS, cap);
    wait_pin("pins released", 16'h5a0f);
    $display("sample extest test done");
  endtask

  task automatic t_busy_cfg();
    int n0;
    @(posedge sys_clk_i);
    cfg_busy_i <= 1'b1;
    u_ctrl.shift_ir(OP_SAMPLE, cap);
    u_ctrl.shift_dr(32'hc3, 8, d);
    check("sample while busy", 32'h86, d);
    u_ctrl.shift_ir(OP_CFG, cap);
    n0 = stb_cnt;
    u_ctrl.shift_dr(32'h96, 8, d);
    check("cfg busy capture", 32'h1, {31'h0, d[0]});
    for (int i = 0; i < 20 && stb_cnt == n0; i++) @(posedge sys_clk_i);
    repeat (6) @(posedge sys_clk_i);
    check("cfg strobes", 32'h1, stb_cnt - n0);
    check("cfg byte", 32'h96, {24'h0, stb_byte});
    @(posedge sys_clk_i);
    cfg_busy_i <= 1'b0;
    $display("busy config test done");
  endtask

  task automatic t_ana();
    @(posedge sys_clk_i);
    probe_i <= 16'hbeef;
    repeat (20) @(posedge sys_clk_i);
    u_ctrl.shift_ir(OP_ANA, cap);
    // Snapshots cross only while the link clock runs; wait past one period
    u_ctrl.idle(80);
    u_ctrl.shift_dr(32'h0, 16, d);
    check("analyzer", 32'hbeef, d);
    $display("analyzer test done");
  endtask

  task automatic t_large();
    logic [IR_W-1:0] ops [5];
    ops = '{OP_EXTEST, OP_SAMPLE, OP_CFG, OP_IDCODE, OP_USER};
    u_ctrl2.reset_tap();
    u_ctrl2.shift_dr(32'hc3, 8, d);
    check("large reset bypass", 32'h86, d);
    foreach (ops[i]) begin
      u_ctrl2.shift_ir(ops[i], cap);
      u_ctrl2.shift_dr(32'hc3, 8, d);
      check("large bypass", 32'h86, d);
    end
    u_ctrl2.shift_ir(OP_ANA, cap);
    u_ctrl2.idle(80);
    u_ctrl2.shift_dr(32'h0, 16, d);
    check("large analyzer", 32'hbeef, d);
    $display("largest member test done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i    = 1'b0;
    pin_i      = '0;
    core_i     = '0;
    cfg_busy_i = 1'b0;
    probe_i    = '0;
    err_count  = 0;
    checks     = 0;
    stb_cnt    = 0;
    stb_byte   = '0;
    u_ctrl.nav(1'b1);
    u_ctrl2.nav(1'b1);
    repeat (2) @(posedge sys_clk_i);
    check("reset outputs", 32'h0, {14'h0, tdo_oe, cfg_stb_o, pin_o});
    rst_n_i <= 1'b1;
    u_ctrl.reset_tap();
    t_user();
    t_idcode();
    t_bypass();
    t_sample_extest();
    t_busy_cfg();
    t_ana();
    t_large();
    give_verdict();
  end

  // Whole run is well under 200 us
  initial begin
    #1_000_000;
    err_count++;
    $display("Error watchdog expired");
    give_verdict();
  end
endmodule
